// ==== src/mic_path_params.svh ====
/*
 * Register offsets, writable-bit masks, reset values and field positions
 * for the microphone input path and converter control block.
 * Assumes a 7-bit word address and 9-bit register words.
 */
`ifndef MIC_PATH_PARAMS_SVH
`define MIC_PATH_PARAMS_SVH

`define ADDR_W 7
`define DATA_W 9

`define OFS_BIAS_POWER 7'h01
`define OFS_BLOCK_POWER 7'h02
`define OFS_SAMPLE_RATE 7'h07
`define OFS_ADC_FILTER 7'h0e
`define OFS_LEVEL_CONFIG 7'h20
`define OFS_INPUT_SELECT 7'h2c
`define OFS_INPUT_GAIN 7'h2d
`define OFS_BOOST_MIX 7'h2f
`define OFS_BIAS_MODE 7'h3a
`define OFS_PATH_STATUS 7'h40

`define MASK_BIAS_POWER 9'h010
`define MASK_BLOCK_POWER 9'h015
`define MASK_SAMPLE_RATE 9'h00e
`define MASK_ADC_FILTER 9'h1f9
`define MASK_LEVEL_CONFIG 9'h13f
`define MASK_INPUT_SELECT 9'h183
`define MASK_INPUT_GAIN 9'h0ff
`define MASK_BOOST_MIX 9'h170
`define MASK_BIAS_MODE 9'h010

`define RST_BIAS_POWER 9'h000
`define RST_BLOCK_POWER 9'h000
`define RST_SAMPLE_RATE 9'h000
`define RST_ADC_FILTER 9'h000
`define RST_LEVEL_CONFIG 9'h038
`define RST_INPUT_SELECT 9'h000
`define RST_INPUT_GAIN 9'h010
`define RST_BOOST_MIX 9'h000
`define RST_BIAS_MODE 9'h000

`define BIAS_EN_BIT 4
`define CONV_EN_BIT 0
`define AMP_EN_BIT 2
`define BOOST_EN_BIT 4
`define RATE_LSB 1
`define POL_BIT 0
`define OSR_BIT 3
`define HP_CODE_LSB 4
`define HP_MODE_BIT 7
`define HP_EN_BIT 8
`define LVL_EN_BIT 8
`define POS_SEL_BIT 0
`define NEG_SEL_BIT 1
`define BIAS_V_LSB 7
`define ZC_BIT 7
`define MUTE_BIT 6
`define AMP_BOOST_BIT 8
`define POS_BOOST_LSB 4
`define BIAS_MODE_BIT 4

// Bias level in percent of supply, entry {mode, code}, entry 0 highest.
`define BIAS_PCT_TABLE {7'h32, 7'h46, 7'h3c, 7'h55, 7'h32, 7'h4b, 7'h41, 7'h5a}

`endif

// ==== src/mic_path_pkg.sv ====
/*
 * Shared types of the microphone input path control block.
 * Assumes the constants of mic_path_params.svh.
 */
package mic_path_pkg;
  typedef logic [8:0] reg_word_type;
  typedef logic [5:0] gain_code_type;
  typedef enum logic [1:0] {
    RATE_GROUP_LOW,
    RATE_GROUP_MID,
    RATE_GROUP_HIGH
  } rate_group_type;
endpackage : mic_path_pkg

// ==== src/gain_select.sv ====
/*
 * Chooses the gain code applied to the input amplifier and, when asked,
 * holds each change until the analogue zero-cross comparator toggles.
 * Assumes zero_cross_pin is asynchronous and level_gain is on clk.
 */
`timescale 1ns/1ps
module gain_select #(parameter int GAIN_W = 6,
                     parameter logic [5:0] GAIN_RST = 6'h10) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [GAIN_W-1:0] manual_gain,
  input wire logic [GAIN_W-1:0] level_gain,
  input wire logic level_enable,
  input wire logic zc_enable,
  input wire logic zero_cross_pin,
  output logic [GAIN_W-1:0] applied_gain
);
  logic [2:0] zc_sync;
  logic zc_level;
  logic zc_event;
  logic [GAIN_W-1:0] target;

  if (GAIN_W != 6) begin : g_bad_width
    $error("gain_select serves a 6-bit gain code only");
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zc_sync <= 3'h0;
    end else begin
      zc_sync <= {zc_sync[1:0], zero_cross_pin};
    end
  end

  // A change counts only once the second and third stages agree.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      zc_level <= 1'b0;
    end else if (zc_sync[1] == zc_sync[2]) begin
      zc_level <= zc_sync[2];
    end
  end

  assign zc_event = (zc_sync[1] == zc_sync[2]) && (zc_sync[2] != zc_level);
  assign target = level_enable ? level_gain : manual_gain;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      applied_gain <= GAIN_RST[GAIN_W-1:0];
    end else if (!zc_enable || zc_event) begin
      applied_gain <= target;
    end
  end
endmodule : gain_select

// ==== src/sample_polarity.sv ====
/*
 * Passes converter words, inverting them on request with saturation.
 * Assumes sample_in arrives on clk with a one-cycle valid.
 */
`timescale 1ns/1ps
module sample_polarity #(parameter int SAMPLE_W = 24) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire logic invert,
  input wire logic [SAMPLE_W-1:0] sample_in,
  input wire logic sample_in_valid,
  output logic [SAMPLE_W-1:0] sample_out,
  output logic sample_out_valid
);
  localparam logic [SAMPLE_W-1:0] MOST_NEG = {1'b1, {(SAMPLE_W-1){1'b0}}};

  if (SAMPLE_W < 2) begin : g_bad_width
    $error("sample_polarity needs at least two bits");
  end

  // Negating the most negative word would wrap, so it saturates instead.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sample_out <= '0;
      sample_out_valid <= 1'b0;
    end else begin
      sample_out_valid <= run && sample_in_valid;
      if (run && sample_in_valid) begin
        if (!invert) begin
          sample_out <= sample_in;
        end else if (sample_in == MOST_NEG) begin
          sample_out <= ~MOST_NEG;
        end else begin
          sample_out <= -sample_in;
        end
      end
    end
  end

  pol_invert_a: assert property (@(posedge clk) disable iff (!reset_n)
    run && invert && sample_in_valid && sample_in != MOST_NEG |=>
    sample_out == -$past(sample_in))
    else $error("inverted word is not the negated input");
endmodule : sample_polarity

// ==== src/mic_input_path_adc_control.sv ====
/*
 * Control registers of the microphone input path and converter front end,
 * decoded into registered controls for the analogue blocks, plus the
 * gain selector and the output word polarity stage.
 * Assumes a single-cycle strobe register port on clk, read data one
 * cycle after the read strobe, and a level controller on the same clock.
 */
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "mic_path_params.svh"
module mic_input_path_adc_control #(parameter int SAMPLE_W = 24) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [`ADDR_W-1:0] addr,
  input wire logic [`DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [`DATA_W-1:0] rd_data,
  input wire logic [5:0] level_gain,
  input wire logic zero_cross_pin,
  input wire logic [SAMPLE_W-1:0] adc_sample,
  input wire logic adc_sample_valid,
  output logic neg_input_select,
  output logic neg_ref_tie,
  output logic pos_input_select,
  output logic pos_ref_tie,
  output logic input_amp_enable,
  output mic_path_pkg::gain_code_type amp_gain,
  output logic amp_to_mixer_connect,
  output logic boost_stage_enable,
  output logic amp_path_boost_select,
  output logic [2:0] pos_pin_boost_gain,
  output logic pos_path_connect,
  output logic bias_output_enable,
  output logic [6:0] bias_ratio_pct,
  output logic converter_enable,
  output logic oversample_select,
  output logic highpass_enable,
  output logic highpass_mode,
  output logic [2:0] highpass_cutoff_code,
  output mic_path_pkg::rate_group_type rate_group,
  output logic [SAMPLE_W-1:0] conv_data,
  output logic conv_valid
);
  localparam int N = 9;
  localparam int I_BIASP = 0;
  localparam int I_PWR = 1;
  localparam int I_RATE = 2;
  localparam int I_FILT = 3;
  localparam int I_LVL = 4;
  localparam int I_SEL = 5;
  localparam int I_GAIN = 6;
  localparam int I_BOOST = 7;
  localparam int I_BMODE = 8;

  localparam logic [`ADDR_W-1:0] REG_ADDR [N] = '{
    `OFS_BIAS_POWER, `OFS_BLOCK_POWER, `OFS_SAMPLE_RATE, `OFS_ADC_FILTER,
    `OFS_LEVEL_CONFIG, `OFS_INPUT_SELECT, `OFS_INPUT_GAIN, `OFS_BOOST_MIX,
    `OFS_BIAS_MODE};
  localparam mic_path_pkg::reg_word_type REG_MASK [N] = '{
    `MASK_BIAS_POWER, `MASK_BLOCK_POWER, `MASK_SAMPLE_RATE,
    `MASK_ADC_FILTER, `MASK_LEVEL_CONFIG, `MASK_INPUT_SELECT,
    `MASK_INPUT_GAIN, `MASK_BOOST_MIX, `MASK_BIAS_MODE};
  localparam mic_path_pkg::reg_word_type REG_RST [N] = '{
    `RST_BIAS_POWER, `RST_BLOCK_POWER, `RST_SAMPLE_RATE, `RST_ADC_FILTER,
    `RST_LEVEL_CONFIG, `RST_INPUT_SELECT, `RST_INPUT_GAIN, `RST_BOOST_MIX,
    `RST_BIAS_MODE};
  localparam mic_path_pkg::reg_word_type GAIN_RST = `RST_INPUT_GAIN;
  localparam logic [55:0] BIAS_TABLE = `BIAS_PCT_TABLE;

  mic_path_pkg::reg_word_type regs [N];
  mic_path_pkg::reg_word_type next_rd_data;
  mic_path_pkg::gain_code_type applied_gain;
  logic [2:0] rate_field;
  logic [2:0] bias_idx;

  if (SAMPLE_W != 24) begin : g_bad_width
    $error("converter words must be 24 bits wide");
  end

  // Only the documented bits are stored; the others stay zero.
  for (genvar i = 0; i < N; i++) begin : g_reg
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        regs[i] <= REG_RST[i];
      end else if (wr_en && addr == REG_ADDR[i]) begin
        regs[i] <= wr_data & REG_MASK[i];
      end
    end
  end

  // Status word: applied gain and whether the level controller owns it.
  always_comb begin
    next_rd_data = '0;
    for (int i = 0; i < N; i++) begin
      if (addr == REG_ADDR[i]) begin
        next_rd_data = regs[i];
      end
    end
    if (addr == `OFS_PATH_STATUS) begin
      next_rd_data = {2'h0, regs[I_LVL][`LVL_EN_BIT], applied_gain};
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_en ? next_rd_data : '0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      neg_input_select <= 1'b0;
      neg_ref_tie <= 1'b1;
      pos_input_select <= 1'b0;
      pos_ref_tie <= 1'b1;
    end else begin
      neg_input_select <= regs[I_SEL][`NEG_SEL_BIT];
      neg_ref_tie <= !regs[I_SEL][`NEG_SEL_BIT];
      pos_ref_tie <= !regs[I_SEL][`POS_SEL_BIT];
      pos_input_select <= regs[I_SEL][`POS_SEL_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      input_amp_enable <= 1'b0;
      amp_to_mixer_connect <= 1'b1;
    end else begin
      input_amp_enable <= regs[I_PWR][`AMP_EN_BIT];
      amp_to_mixer_connect <= !regs[I_GAIN][`MUTE_BIT];
    end
  end

  gain_select #(.GAIN_W(6), .GAIN_RST(GAIN_RST[5:0])) u_gain (
    .clk(clk),
    .reset_n(reset_n),
    .manual_gain(regs[I_GAIN][5:0]),
    .level_gain(level_gain),
    .level_enable(regs[I_LVL][`LVL_EN_BIT]),
    .zc_enable(regs[I_GAIN][`ZC_BIT]),
    .zero_cross_pin(zero_cross_pin),
    .applied_gain(applied_gain)
  );

  // The selector already ends in a flop; this stage keeps the port timing.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      amp_gain <= GAIN_RST[5:0];
    end else begin
      amp_gain <= applied_gain;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boost_stage_enable <= 1'b0;
      amp_path_boost_select <= 1'b0;
      pos_pin_boost_gain <= 3'h0;
      pos_path_connect <= 1'b0;
    end else begin
      boost_stage_enable <= regs[I_PWR][`BOOST_EN_BIT];
      amp_path_boost_select <= regs[I_BOOST][`AMP_BOOST_BIT];
      pos_pin_boost_gain <= regs[I_BOOST][`POS_BOOST_LSB +: 3];
      pos_path_connect <= regs[I_BOOST][`POS_BOOST_LSB +: 3] != 3'h0;
    end
  end

  assign bias_idx = {regs[I_BMODE][`BIAS_MODE_BIT],
                     regs[I_SEL][`BIAS_V_LSB +: 2]};

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bias_output_enable <= 1'b0;
      bias_ratio_pct <= BIAS_TABLE[6:0];
    end else begin
      bias_output_enable <= regs[I_BIASP][`BIAS_EN_BIT];
      bias_ratio_pct <= BIAS_TABLE[bias_idx*7 +: 7];
    end
  end

  assign rate_field = regs[I_RATE][`RATE_LSB +: 3];

  // Rate codes pair off: 1x0/1x1 low, 01x mid, 00x high.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      converter_enable <= 1'b0;
      oversample_select <= 1'b0;
      highpass_enable <= 1'b0;
      highpass_mode <= 1'b0;
      highpass_cutoff_code <= 3'h0;
      rate_group <= mic_path_pkg::RATE_GROUP_HIGH;
    end else begin
      converter_enable <= regs[I_PWR][`CONV_EN_BIT];
      oversample_select <= regs[I_FILT][`OSR_BIT];
      highpass_enable <= regs[I_FILT][`HP_EN_BIT];
      highpass_mode <= regs[I_FILT][`HP_MODE_BIT];
      highpass_cutoff_code <= regs[I_FILT][`HP_CODE_LSB +: 3];
      if (rate_field[2]) begin
        rate_group <= mic_path_pkg::RATE_GROUP_LOW;
      end else if (rate_field[1]) begin
        rate_group <= mic_path_pkg::RATE_GROUP_MID;
      end else begin
        rate_group <= mic_path_pkg::RATE_GROUP_HIGH;
      end
    end
  end

  sample_polarity #(.SAMPLE_W(SAMPLE_W)) u_pol (
    .clk(clk),
    .reset_n(reset_n),
    .run(regs[I_PWR][`CONV_EN_BIT]),
    .invert(regs[I_FILT][`POL_BIT]),
    .sample_in(adc_sample),
    .sample_in_valid(adc_sample_valid),
    .sample_out(conv_data),
    .sample_out_valid(conv_valid)
  );

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  neg_route_a: assert property (
    wr_en && addr == `OFS_INPUT_SELECT |-> ##2
    neg_input_select == $past(wr_data[`NEG_SEL_BIT], 2))
    else $error("negative pin routing does not follow the write");

  neg_tie_a: assert property (
    neg_ref_tie == !neg_input_select && neg_ref_tie == $past(
    !regs[I_SEL][`NEG_SEL_BIT]))
    else $error("negative pin reference tie is wrong");

  pos_tie_a: assert property (
    pos_ref_tie == $past(!regs[I_SEL][`POS_SEL_BIT]))
    else $error("positive terminal reference tie is wrong");

  pos_route_a: assert property (
    wr_en && addr == `OFS_INPUT_SELECT |-> ##2
    pos_input_select == $past(wr_data[`POS_SEL_BIT], 2))
    else $error("positive pin routing does not follow the write");

  amp_power_a: assert property (
    wr_en && addr == `OFS_BLOCK_POWER |-> ##2
    input_amp_enable == $past(wr_data[`AMP_EN_BIT], 2))
    else $error("amplifier power does not follow its enable");

  manual_gain_a: assert property (
    (!regs[I_LVL][`LVL_EN_BIT] && !regs[I_GAIN][`ZC_BIT] &&
     $stable(regs[I_GAIN]))[*3] |-> amp_gain == regs[I_GAIN][5:0])
    else $error("applied gain differs from the manual code");

  level_gain_a: assert property (
    (regs[I_LVL][`LVL_EN_BIT] && !regs[I_GAIN][`ZC_BIT] &&
     $stable(level_gain))[*3] |-> amp_gain == level_gain)
    else $error("level controller gain not applied");

  gain_fixed_a: assert property (
    rd_en && addr == `OFS_INPUT_GAIN |=> rd_data[8] == 1'b0)
    else $error("fixed bit of the gain register reads non-zero");

  boost_power_a: assert property (
    wr_en && addr == `OFS_BLOCK_POWER |-> ##2
    boost_stage_enable == $past(wr_data[`BOOST_EN_BIT], 2))
    else $error("boost stage power does not follow its bit");

  mute_path_a: assert property (
    wr_en && addr == `OFS_INPUT_GAIN |-> ##2
    amp_to_mixer_connect == !$past(wr_data[`MUTE_BIT], 2))
    else $error("mute does not cut the amplifier path");

  amp_boost_a: assert property (
    wr_en && addr == `OFS_BOOST_MIX |-> ##2
    amp_path_boost_select == $past(wr_data[`AMP_BOOST_BIT], 2))
    else $error("amplifier path boost does not follow its bit");

  pos_cut_a: assert property (
    pos_path_connect == (pos_pin_boost_gain != 3'h0))
    else $error("positive pin path connect disagrees with its code");

  bias_enable_a: assert property (
    wr_en && addr == `OFS_BIAS_POWER |-> ##2
    bias_output_enable == $past(wr_data[`BIAS_EN_BIT], 2))
    else $error("bias output does not follow its enable");

  bias_level_a: assert property (
    $past(bias_idx) == 3'h0 |-> bias_ratio_pct == 7'h5a)
    else $error("bias level for code zero mode zero is wrong");

  conv_run_a: assert property (
    conv_valid |-> $past(regs[I_PWR][`CONV_EN_BIT]))
    else $error("converter word while converter is off");

  osr_sel_a: assert property (
    wr_en && addr == `OFS_ADC_FILTER |-> ##2
    oversample_select == $past(wr_data[`OSR_BIT], 2))
    else $error("oversampling select does not follow its bit");

  hp_ctrl_a: assert property (
    wr_en && addr == `OFS_ADC_FILTER |-> ##2
    highpass_cutoff_code == $past(wr_data[6:4], 2) &&
    highpass_mode == $past(wr_data[`HP_MODE_BIT], 2))
    else $error("high-pass controls do not follow the write");

  rate_grp_a: assert property (
    $past(rate_field) == 3'h3 |-> rate_group == mic_path_pkg::RATE_GROUP_MID)
    else $error("sample rate group is wrong");

  read_zero_a: assert property (
    !rd_en |=> rd_data == '0)
    else $error("read data present without a read strobe");

  diff_input_c: cover property (neg_input_select && pos_input_select);
  level_ctl_c: cover property (regs[I_LVL][`LVL_EN_BIT] && conv_valid);
  invert_c: cover property (conv_valid && regs[I_FILT][`POL_BIT]);
  status_rd_c: cover property (rd_en && addr == `OFS_PATH_STATUS);
endmodule : mic_input_path_adc_control

// ==== verification/mic_input_path_adc_control_tb.sv ====
/*
 * Self-checking bench for the microphone path control block.
 * Assumes the strobe register port with read data one cycle after rd_en.
 */
`timescale 1ns/1ps
`include "mic_path_params.svh"
module mic_input_path_adc_control_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [8:0] wr_data = 9'h000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [8:0] rd_data;
  logic [5:0] level_gain = 6'h00;
  logic zero_cross_pin = 1'b0;
  logic [23:0] adc_sample = 24'h000000;
  logic adc_sample_valid = 1'b0;
  logic neg_sel, neg_tie, pos_sel, pos_tie, amp_en, mix_conn;
  mic_path_pkg::gain_code_type amp_gain;
  logic boost_en, amp_boost, pos_conn, bias_en, conv_en, osr;
  logic [2:0] pos_boost, hp_code;
  logic [6:0] bias_pct;
  logic hp_en, hp_mode, conv_valid;
  mic_path_pkg::rate_group_type rate_group;
  logic [23:0] conv_data;
  int fails = 0;
  int compares = 0;
  int cycles = 0;
  logic [6:0] bias_tab [8] = '{7'h5a, 7'h41, 7'h4b, 7'h32,
                               7'h55, 7'h3c, 7'h46, 7'h32};

  always #2.5 clk = ~clk;

  mic_input_path_adc_control dut (
    .clk(clk), .reset_n(reset_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .level_gain(level_gain), .zero_cross_pin(zero_cross_pin),
    .adc_sample(adc_sample), .adc_sample_valid(adc_sample_valid),
    .neg_input_select(neg_sel), .neg_ref_tie(neg_tie),
    .pos_input_select(pos_sel), .pos_ref_tie(pos_tie),
    .input_amp_enable(amp_en), .amp_gain(amp_gain),
    .amp_to_mixer_connect(mix_conn), .boost_stage_enable(boost_en),
    .amp_path_boost_select(amp_boost), .pos_pin_boost_gain(pos_boost),
    .pos_path_connect(pos_conn), .bias_output_enable(bias_en),
    .bias_ratio_pct(bias_pct), .converter_enable(conv_en),
    .oversample_select(osr), .highpass_enable(hp_en),
    .highpass_mode(hp_mode), .highpass_cutoff_code(hp_code),
    .rate_group(rate_group), .conv_data(conv_data),
    .conv_valid(conv_valid)
  );

  task automatic check(input string what, input logic [23:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Cycles plus a settle delay, so outputs are read after they land.
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_n

  // A write is taken at the edge after the strobe goes up; outputs show
  // the new value one edge after that, amp_gain one edge later still.
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    wait_n(1);
  endtask : wr

  task automatic rd_chk(input logic [6:0] a, input logic [8:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check("rd_data", 24'(rd_data), 24'(exp));
    wait_n(1);
    check("rd_data idle", 24'(rd_data), 24'h0);
  endtask : rd_chk

  task automatic smp(input logic [23:0] d, input logic v,
                     input logic [23:0] e);
    @(posedge clk);
    adc_sample <= d;
    adc_sample_valid <= 1'b1;
    @(posedge clk);
    adc_sample_valid <= 1'b0;
    adc_sample <= ~d;
    #1;
    check("conv_valid", 24'(conv_valid), 24'(v));
    if (v) check("conv_data", conv_data, e);
  endtask : smp

  task automatic test_reset();
    check("neg_tie", 24'(neg_tie), 24'h1);
    check("pos_tie", 24'(pos_tie), 24'h1);
    check("amp_gain", 24'(amp_gain), 24'h10);
    check("bias_pct", 24'(bias_pct), 24'h5a);
    check("conv_en", 24'(conv_en), 24'h0);
    rd_chk(`OFS_LEVEL_CONFIG, 9'h038);
    rd_chk(`OFS_INPUT_GAIN, 9'h010);
    rd_chk(`OFS_ADC_FILTER, 9'h000);
    rd_chk(7'h10, 9'h000);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_select();
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_INPUT_SELECT, 9'(i));
      check("neg_sel", 24'(neg_sel), 24'(i[1]));
      check("neg_tie", 24'(neg_tie), 24'(!i[1]));
      check("pos_tie", 24'(pos_tie), 24'(!i[0]));
      check("pos_sel", 24'(pos_sel), 24'(i[0]));
    end
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_BIAS_MODE, {4'h0, i[2], 4'h0});
      wr(`OFS_INPUT_SELECT, {i[1:0], 7'h00});
      check("bias_pct", 24'(bias_pct), 24'(bias_tab[i]));
    end
    wr(`OFS_BIAS_POWER, 9'h010);
    check("bias_en", 24'(bias_en), 24'h1);
    wr(`OFS_BIAS_POWER, 9'h1ef);
    check("bias_en", 24'(bias_en), 24'h0);
    $display("test_select done");
  endtask : test_select

  task automatic test_power();
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_BLOCK_POWER, {4'h0, i[2], 1'b0, i[1], 1'b0, i[0]});
      check("boost_en", 24'(boost_en), 24'(i[2]));
      check("amp_en", 24'(amp_en), 24'(i[1]));
      check("conv_en", 24'(conv_en), 24'(i[0]));
    end
    $display("test_power done");
  endtask : test_power

  task automatic test_gain();
    wr(`OFS_INPUT_GAIN, 9'h000);
    wait_n(3);
    check("amp_gain", 24'(amp_gain), 24'h00);
    wr(`OFS_INPUT_GAIN, 9'h06a);
    wait_n(3);
    check("amp_gain", 24'(amp_gain), 24'h2a);
    check("mix_conn", 24'(mix_conn), 24'h0);
    wr(`OFS_INPUT_GAIN, 9'h17f);
    rd_chk(`OFS_INPUT_GAIN, 9'h07f);
    @(posedge clk);
    level_gain <= 6'h15;
    wr(`OFS_LEVEL_CONFIG, 9'h138);
    wait_n(3);
    check("amp_gain", 24'(amp_gain), 24'h15);
    rd_chk(`OFS_PATH_STATUS, 9'h055);
    @(posedge clk);
    level_gain <= 6'h33;
    wait_n(4);
    check("amp_gain", 24'(amp_gain), 24'h33);
    wr(`OFS_LEVEL_CONFIG, 9'h038);
    wait_n(3);
    check("amp_gain", 24'(amp_gain), 24'h3f);
    wr(`OFS_INPUT_GAIN, 9'h000);
    wait_n(3);
    check("mix_conn", 24'(mix_conn), 24'h1);
    wr(`OFS_INPUT_GAIN, 9'h090);
    wait_n(8);
    check("amp_gain held", 24'(amp_gain), 24'h00);
    @(posedge clk);
    zero_cross_pin <= 1'b1;
    wait_n(10);
    check("amp_gain zc", 24'(amp_gain), 24'h10);
    $display("test_gain done");
  endtask : test_gain

  task automatic test_boost();
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_BOOST_MIX, {i[0], 1'b0, i[2:0], 4'hf});
      check("amp_boost", 24'(amp_boost), 24'(i[0]));
      check("pos_boost", 24'(pos_boost), 24'(i[2:0]));
      check("pos_conn", 24'(pos_conn), 24'(i != 0));
    end
    $display("test_boost done");
  endtask : test_boost

  task automatic test_filter();
    logic [1:0] grp [8] = '{2'h2, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0};
    wr(`OFS_ADC_FILTER, 9'h0a8);
    check("osr", 24'(osr), 24'h1);
    check("hp_en", 24'(hp_en), 24'h0);
    check("hp_mode", 24'(hp_mode), 24'h1);
    check("hp_code", 24'(hp_code), 24'h2);
    wr(`OFS_ADC_FILTER, 9'h156);
    check("osr", 24'(osr), 24'h0);
    check("hp_en", 24'(hp_en), 24'h1);
    check("hp_mode", 24'(hp_mode), 24'h0);
    check("hp_code", 24'(hp_code), 24'h5);
    wr(`OFS_ADC_FILTER, 9'h1ff);
    rd_chk(`OFS_ADC_FILTER, 9'h1f9);
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_SAMPLE_RATE, {5'h00, i[2:0], 1'b1});
      check("rate_group", 24'(rate_group), 24'(grp[i]));
    end
    $display("test_filter done");
  endtask : test_filter

  task automatic test_samples();
    wr(`OFS_BLOCK_POWER, 9'h000);
    smp(24'h123456, 1'b0, 24'h0);
    wr(`OFS_BLOCK_POWER, 9'h001);
    wr(`OFS_ADC_FILTER, 9'h000);
    smp(24'h123456, 1'b1, 24'h123456);
    smp(24'h800000, 1'b1, 24'h800000);
    wr(`OFS_ADC_FILTER, 9'h001);
    smp(24'h000001, 1'b1, 24'hffffff);
    smp(24'h800000, 1'b1, 24'h7fffff);
    smp(24'h7fffff, 1'b1, 24'h800001);
    $display("test_samples done");
  endtask : test_samples

  // Ends a run that hangs; the tests need a few hundred cycles.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    wait_n(1);
    test_reset();
    test_select();
    test_power();
    test_gain();
    test_boost();
    test_filter();
    test_samples();
    // A reset in mid-run must bring every field back to its default.
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    wait_n(1);
    test_reset();
    tally_and_finish();
  end
endmodule : mic_input_path_adc_control_tb
